// [pll_clock_source_config.sv]
// Staged register file, clock routing and charge pump control
`timescale 1ns/1ps
module pll_clock_source_config
import pll_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // Register port
   input  wire logic [9:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   // Divider edges from outside the clock domain
   input  wire logic       ref_div_in,
   input  wire logic       fb_div_in,
   // Analogue control
   output logic            pll_power_down,
   output logic            divider_bypass,
   output logic            internal_vco_select,
   output logic            charge_pump_up,
   output logic            charge_pump_down,
   output logic            charge_pump_hiz,
   output logic      [2:0] charge_pump_current,
   output logic            vco_cal_start
);
   // Staged copies written by software
   logic [7:0] st_power_pump;
   logic [7:0] st_abl;
   logic [7:0] st_cal;
   logic [7:0] st_current;
   logic [7:0] st_source;
   // Active copies steering the logic
   logic [7:0] act_power_pump;
   logic [7:0] act_abl;
   logic [7:0] act_cal;
   logic [7:0] act_current;
   logic [7:0] act_source;
   logic       update_pending;
   logic       cal_armed;
   logic       ref_rise;
   logic       fb_rise;
   logic       ref_level;
   logic       fb_level;
   logic       det_up;
   logic       det_down;
   logic       up_sense;
   logic       dn_sense;
   logic [1:0] act_power;
   logic [2:0] act_mode;
   logic       polarity_neg;

   edge_sync ref_sync
   (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .async_in (ref_div_in),
      .level    (ref_level),
      .rise     (ref_rise)
   );

   edge_sync fb_sync
   (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .async_in (fb_div_in),
      .level    (fb_level),
      .rise     (fb_rise)
   );

   // Staged register writes
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         st_power_pump <= power_pump_reset;
         st_abl        <= antibacklash_reset;
         st_cal        <= vco_cal_reset;
         st_current    <= pump_current_reset;
         st_source     <= source_select_reset;
      end
      else if (reg_write)
      begin
         unique case (reg_addr)
            power_pump_offset:    st_power_pump <= reg_wdata;
            antibacklash_offset:  st_abl        <= reg_wdata;
            vco_cal_offset:       st_cal        <= reg_wdata;
            pump_current_offset:  st_current    <= reg_wdata;
            source_select_offset: st_source     <= reg_wdata;
            default:              ;
         endcase
      end
   end

   // Update strobe: only 0x01 arms, the bit drops once transfer is done
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         update_pending <= 1'b0;
      else if (reg_write && reg_addr == update_strobe_offset
               && reg_wdata == update_value)
         update_pending <= 1'b1;
      else
         update_pending <= 1'b0;
   end

   // Transfer staged to active one cycle after the update write
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         act_power_pump <= power_pump_reset;
         act_abl        <= antibacklash_reset;
         act_cal        <= vco_cal_reset;
         act_current    <= pump_current_reset;
         act_source     <= source_select_reset;
      end
      else if (update_pending)
      begin
         act_power_pump <= st_power_pump;
         act_abl        <= st_abl;
         act_cal        <= st_cal;
         act_current    <= st_current;
         act_source     <= st_source;
      end
   end

   assign act_power    = act_power_pump[power_msb:power_lsb];
   assign act_mode     = act_power_pump[pump_mode_msb:pump_mode_lsb];
   assign polarity_neg = act_power_pump[polarity_bit];

   // Calibration starts on a 0 to 1 transfer of the active bit only;
   // software must clear and update before the next run
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         cal_armed     <= 1'b1;
         vco_cal_start <= 1'b0;
      end
      else
      begin
         vco_cal_start <= 1'b0;
         if (!act_cal[cal_start_bit])
            cal_armed <= 1'b1;
         else if (cal_armed)
         begin
            cal_armed     <= 1'b0;
            vco_cal_start <= 1'b1;
         end
      end
   end

   pfd_core detector
   (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .ref_rise (ref_rise),
      .fb_rise  (fb_rise),
      .abl_sel  (act_abl[1:0]),
      .up       (det_up),
      .down     (det_down)
   );

   // Polarity swaps sense only for an external oscillator
   always_comb
   begin
      if (polarity_neg && !act_source[vco_select_bit])
      begin
         up_sense = det_down;
         dn_sense = det_up;
      end
      else
      begin
         up_sense = det_up;
         dn_sense = det_down;
      end
   end

   // Analogue controls registered from the active set
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pll_power_down      <= 1'b1;
         divider_bypass      <= 1'b0;
         internal_vco_select <= 1'b0;
         charge_pump_current <= pump_current_reset[2:0];
      end
      else
      begin
         pll_power_down      <= act_power != power_normal;
         divider_bypass      <= act_source[bypass_bit];
         internal_vco_select <= act_source[vco_select_bit];
         charge_pump_current <= act_current[2:0];
      end
   end

   // Pump drive; powered down PLL leaves the pump floating
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         charge_pump_up   <= 1'b0;
         charge_pump_down <= 1'b0;
         charge_pump_hiz  <= 1'b1;
      end
      else if (act_power != power_normal)
      begin
         charge_pump_up   <= 1'b0;
         charge_pump_down <= 1'b0;
         charge_pump_hiz  <= 1'b1;
      end
      else
      begin
         unique case (act_mode)
            pump_normal:
            begin
               charge_pump_up   <= up_sense;
               charge_pump_down <= dn_sense;
               charge_pump_hiz  <= 1'b0;
            end
            pump_force_up:
            begin
               charge_pump_up   <= 1'b1;
               charge_pump_down <= 1'b0;
               charge_pump_hiz  <= 1'b0;
            end
            pump_force_dn:
            begin
               charge_pump_up   <= 1'b0;
               charge_pump_down <= 1'b1;
               charge_pump_hiz  <= 1'b0;
            end
            default:
            begin
               charge_pump_up   <= 1'b0;
               charge_pump_down <= 1'b0;
               charge_pump_hiz  <= 1'b1;
            end
         endcase
      end
   end

   // Reads return staged values, the strobe its pending bit; status shows live divider levels
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         reg_rdata <= 8'h00;
      else if (reg_read)
      begin
         unique case (reg_addr)
            power_pump_offset:    reg_rdata <= st_power_pump;
            antibacklash_offset:  reg_rdata <= st_abl;
            vco_cal_offset:       reg_rdata <= st_cal;
            pump_current_offset:  reg_rdata <= st_current;
            source_select_offset: reg_rdata <= st_source;
            update_strobe_offset: reg_rdata <= {7'h00, update_pending};
            loop_status_offset:
               reg_rdata <= {4'h0, det_down, det_up, fb_level, ref_level};
            default:              reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end

   // Assertions
   sequence update_write_s;
      reg_write && reg_addr == update_strobe_offset
         && reg_wdata == update_value;
   endsequence

   sequence transfer_s;
      ##1 update_pending ##1 act_power_pump == $past(st_power_pump);
   endsequence

   staged_apply_a: assert property (@(posedge sys_clk) disable iff (reset)
      update_write_s |-> transfer_s)
      else $error("update did not transfer staged values");

   no_update_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      !update_pending |=> $stable(act_source))
      else $error("active source changed without update");

   // A fresh update write in the pending cycle may legally re-arm it
   update_clear_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      update_pending && !(reg_write && reg_addr == update_strobe_offset
         && reg_wdata == update_value) |=> !update_pending)
      else $error("update bit did not clear");

   power_down_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      act_power == power_async_down |=> pll_power_down && charge_pump_hiz)
      else $error("PLL not powered down");

   power_run_a: assert property (@(posedge sys_clk) disable iff (reset)
      act_power == power_normal |=> !pll_power_down)
      else $error("PLL not running");

   bypass_route_a: assert property (@(posedge sys_clk) disable iff (reset)
      1'b1 |=> divider_bypass == $past(act_source[bypass_bit]))
      else $error("divider bypass mismatch");

   source_sel_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      1'b1 |=> internal_vco_select == $past(act_source[vco_select_bit]))
      else $error("source select mismatch");

   force_up_a: assert property (@(posedge sys_clk) disable iff (reset)
      act_power == power_normal && act_mode == pump_force_up
      |=> charge_pump_up && !charge_pump_down)
      else $error("forced pump up not applied");

   polarity_swap_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      act_power == power_normal && act_mode == pump_normal && polarity_neg
      && !act_source[vco_select_bit] |=> charge_pump_up == $past(det_down))
      else $error("negative polarity not applied");

   cal_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
      vco_cal_start |=> !vco_cal_start)
      else $error("calibration start longer than one cycle");
endmodule : pll_clock_source_config

// [pll_cfg_pkg.sv]
// Register map, field layout and reset values for the clock source block
package pll_cfg_pkg;
   localparam logic [9:0] power_pump_offset     = 10'h010;
   localparam logic [9:0] antibacklash_offset   = 10'h017;
   localparam logic [9:0] vco_cal_offset        = 10'h018;
   localparam logic [9:0] pump_current_offset   = 10'h019;
   localparam logic [9:0] source_select_offset  = 10'h1e1;
   localparam logic [9:0] update_strobe_offset  = 10'h232;
   localparam logic [9:0] loop_status_offset    = 10'h1f0;

   localparam int power_lsb      = 0;
   localparam int power_msb      = 1;
   localparam int pump_mode_lsb  = 4;
   localparam int pump_mode_msb  = 6;
   localparam int polarity_bit   = 7;
   localparam int bypass_bit     = 0;
   localparam int vco_select_bit = 1;
   localparam int cal_start_bit  = 0;
   localparam int update_bit     = 0;

   localparam logic [1:0] power_normal = 2'h0;
   localparam logic [1:0] power_async_down = 2'h1;

   localparam logic [2:0] pump_hiz       = 3'h0;
   localparam logic [2:0] pump_force_up  = 3'h1;
   localparam logic [2:0] pump_force_dn  = 3'h2;
   localparam logic [2:0] pump_normal    = 3'h3;

   localparam logic [7:0] power_pump_reset    = 8'h01;
   localparam logic [7:0] antibacklash_reset  = 8'h00;
   localparam logic [7:0] vco_cal_reset       = 8'h00;
   localparam logic [7:0] pump_current_reset  = 8'h07;
   localparam logic [7:0] source_select_reset = 8'h00;
   localparam logic [7:0] update_value        = 8'h01;

   // Antibacklash widths in system clock cycles per field code
   localparam logic [3:0] abl_width_0 = 4'h2;
   localparam logic [3:0] abl_width_1 = 4'h1;
   localparam logic [3:0] abl_width_2 = 4'h3;
   localparam logic [3:0] abl_width_3 = 4'h2;
endpackage : pll_cfg_pkg

// [edge_sync.sv]
// Two-stage synchroniser with rising edge detect
`timescale 1ns/1ps
module edge_sync
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset,
   // Signal
   input  wire logic async_in,
   output logic      level,
   output logic      rise
);
   logic meta;
   logic prev;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         meta  <= 1'b0;
         level <= 1'b0;
         prev  <= 1'b0;
      end
      else
      begin
         meta  <= async_in;
         level <= meta;
         prev  <= level;
      end
   end

   assign rise = level & ~prev;
endmodule : edge_sync

// [pfd_core.sv]
// Phase frequency detector with programmable antibacklash overlap
`timescale 1ns/1ps
module pfd_core
import pll_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // Divider edges and settings
   input  wire logic       ref_rise,
   input  wire logic       fb_rise,
   input  wire logic [1:0] abl_sel,
   // Detector outputs
   output logic            up,
   output logic            down
);
   logic       up_st;
   logic       dn_st;
   logic [3:0] abl_count;
   logic [3:0] abl_len;

   always_comb
   begin
      unique case (abl_sel)
         2'h0: abl_len = abl_width_0;
         2'h1: abl_len = abl_width_1;
         2'h2: abl_len = abl_width_2;
         2'h3: abl_len = abl_width_3;
      endcase
   end

   // Both flops set means the edges met; hold both for the overlap then clear
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         up_st     <= 1'b0;
         dn_st     <= 1'b0;
         abl_count <= 4'h0;
      end
      else if (up_st && dn_st)
      begin
         if (abl_count >= abl_len)
         begin
            up_st     <= ref_rise;
            dn_st     <= fb_rise;
            abl_count <= 4'h0;
         end
         else
            abl_count <= abl_count + 4'h1;
      end
      else
      begin
         up_st <= up_st | ref_rise;
         dn_st <= dn_st | fb_rise;
      end
   end

   assign up   = up_st;
   assign down = dn_st;
endmodule : pfd_core

// [vco_source_model.sv]
// Behavioural far-side source that forms the divider edges
`timescale 1ns/1ps
module vco_source_model
(
   // Requests from the bench
   input  wire logic ref_req,
   input  wire logic fb_req,
   input  wire logic cal_run,
   // Divider outputs toward the block
   output logic      ref_div_in,
   output logic      fb_div_in
);
   logic tick = 1'b0;

   // Both dividers keep running while the VCO calibrates
   always #130 tick = ~tick;
   // Skewed from the system clock so the sync stages see real async edges
   assign #7 ref_div_in = ref_req ^ (cal_run & tick);
   assign #7 fb_div_in  = fb_req ^ (cal_run & tick);
endmodule : vco_source_model

// [pll_clock_source_config_tb.sv]
// Self-checking bench for the clock source configuration block
`timescale 1ns/1ps
module pll_clock_source_config_tb
import pll_cfg_pkg::*;
;
   logic       sys_clk, reset, reg_write, reg_read;
   logic [9:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, n, seed_word;
   logic       pll_power_down, divider_bypass, internal_vco_select;
   logic       charge_pump_up, charge_pump_down, charge_pump_hiz;
   logic [2:0] charge_pump_current, md, cur;
   logic       vco_cal_start, ref_req, fb_req, cal_run, ref_div_in, fb_div_in;
   logic [1:0] pw, src;
   logic [8:0] last;
   logic [7:0] abl_n [4];
   logic [3:0] abl_w [4] = '{abl_width_0, abl_width_1, abl_width_2,
      abl_width_3};
   logic [1:0] det_exp [4] = '{2'h2, 2'h1, 2'h2, 2'h1};
   int         error_cnt, samples_checked, i;
   wire  [8:0] outs = {pll_power_down, divider_bypass, internal_vco_select,
      charge_pump_up, charge_pump_down, charge_pump_hiz, charge_pump_current};
   wire  [1:0] pump_ud = {charge_pump_up, charge_pump_down};

   pll_clock_source_config pll_clock_source_config_inst
   (
      .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .ref_div_in(ref_div_in), .fb_div_in(fb_div_in),
      .pll_power_down(pll_power_down), .divider_bypass(divider_bypass),
      .internal_vco_select(internal_vco_select),
      .charge_pump_up(charge_pump_up), .charge_pump_down(charge_pump_down),
      .charge_pump_hiz(charge_pump_hiz),
      .charge_pump_current(charge_pump_current),
      .vco_cal_start(vco_cal_start)
   );

   vco_source_model vco_source_model_inst
   (
      .ref_req(ref_req), .fb_req(fb_req), .cal_run(cal_run),
      .ref_div_in(ref_div_in), .fb_div_in(fb_div_in)
   );

   function automatic logic [8:0] exp_out(input logic [1:0] p,
      input logic [2:0] m, input logic [1:0] s, input logic [2:0] c);
      logic run;
      // A powered down PLL floats the pump whatever the mode field says
      run = (p == power_normal);
      exp_out = {!run, s[bypass_bit], s[vco_select_bit],
         run && m == pump_force_up, run && m == pump_force_dn,
         !run || !(m inside {pump_force_up, pump_force_dn, pump_normal}), c};
   endfunction : exp_out

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
      input string what);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : wr

   task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, e, "read data");
   endtask : rdchk

   // Four edges covers the load walk with two cycles of margin
   task automatic upd();
      wr(update_strobe_offset, update_value);
      repeat (4) @(posedge sys_clk);
      #1;
   endtask : upd

   task automatic cal(input logic [7:0] e);
      wr(update_strobe_offset, update_value);
      n = 8'h00;
      repeat (8)
      begin
         @(posedge sys_clk);
         #1 n = n + vco_cal_start;
      end
      chk(n, e, "calibration pulses");
   endtask : cal

   task automatic stop_test();
      if (error_cnt == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   initial
   begin
      #100000;
      error_cnt++;
      stop_test();
   end

   initial
   begin
      reset = 1'b1;
      {reg_write, reg_read, ref_req, fb_req, cal_run} = 5'h00;
      reg_addr = 10'h000;
      reg_wdata = 8'h00;
      error_cnt = 0;
      samples_checked = 0;
      seed_word = 8'($urandom(14615));
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      #1 chk(outs, 9'h10f, "reset outputs");
      rdchk(power_pump_offset, power_pump_reset);
      rdchk(source_select_offset, source_select_reset);
      rdchk(antibacklash_offset, antibacklash_reset);
      rdchk(pump_current_offset, pump_current_reset);
      rdchk(10'h0ff, 8'h00);
      wr(power_pump_offset, 8'h00);
      wr(update_strobe_offset, 8'h02);
      repeat (4) @(posedge sys_clk);
      #1 chk(outs, 9'h10f, "bad update value");
      upd();
      last = exp_out(power_normal, pump_hiz, 2'h0, 3'h7);
      chk(outs, last, "pll running");
      rdchk(update_strobe_offset, 8'h00);
      // Random settings with every low pump mode forced in first
      for (i = 0; i < 10; i++)
      begin
         pw  = 2'($urandom);
         md  = (i < 4) ? 3'(i) : 3'($urandom);
         src = 2'($urandom);
         cur = 3'($urandom);
         wr(power_pump_offset, {1'b0, md, 2'h0, pw});
         wr(source_select_offset, {6'h00, src});
         wr(pump_current_offset, {5'h00, cur});
         #1 chk(outs, last, "staged only");
         upd();
         last = exp_out(pw, md, src, cur);
         chk(outs, last, "active");
         rdchk(power_pump_offset, {1'b0, md, 2'h0, pw});
         rdchk(pump_current_offset, {5'h00, cur});
      end
      // Lead edge, polarity and source per case: ext, ext neg, int neg, fb lead
      for (i = 0; i < 4; i++)
      begin
         wr(power_pump_offset, {i == 1 || i == 2, pump_normal, 4'h0});
         wr(source_select_offset, (i == 2) ? 8'h02 : 8'h00);
         upd();
         ref_req <= (i != 3);
         fb_req  <= (i == 3);
         repeat (6) @(posedge sys_clk);
         #1 chk(pump_ud, det_exp[i], "lead");
         // Status holds the leading divider level and its detector flop
         rdchk(loop_status_offset, (i == 3) ? 8'h0a : 8'h05);
         ref_req <= 1'b1;
         fb_req  <= 1'b1;
         repeat (10) @(posedge sys_clk);
         #1 chk(pump_ud, 2'h0, "aligned");
         ref_req <= 1'b0;
         fb_req  <= 1'b0;
         repeat (6) @(posedge sys_clk);
      end
      // Offsets cancel when widths are compared against code one
      for (i = 0; i < 4; i++)
      begin
         wr(antibacklash_offset, 8'(i));
         upd();
         ref_req <= 1'b1;
         fb_req  <= 1'b1;
         n = 8'h00;
         repeat (12)
         begin
            @(posedge sys_clk);
            #1 n = n + charge_pump_up;
         end
         abl_n[i] = n;
         ref_req <= 1'b0;
         fb_req  <= 1'b0;
         repeat (6) @(posedge sys_clk);
      end
      for (i = 0; i < 4; i++)
         chk(abl_n[i] - abl_n[1], abl_w[i] - abl_w[1], "overlap");
      cal_run <= 1'b1;
      wr(vco_cal_offset, 8'h01);
      cal(8'h01);
      cal(8'h00);
      wr(vco_cal_offset, 8'h00);
      cal(8'h00);
      wr(vco_cal_offset, 8'h01);
      cal(8'h01);
      cal_run <= 1'b0;
      stop_test();
   end
endmodule : pll_clock_source_config_tb
